// file: hw/bsphio_core.sv
`timescale 1ns/1ps
`include "bsphio_regs.svh"
module bsphio_core #(
   parameter int DATA_W = `BSPHIO_DATA_W,
   parameter int PAGE_DEPTH = `BSPHIO_PAGE_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input bsphio_pkg::bsphio_instr_type instr,
   input wire logic wakeUp,
   input wire logic wdtTick,
   output logic instrReady,
   output logic [7:0] accumulator,
   output bsphio_pkg::bsphio_flags_type flags,
   output logic [7:0] watchdogCounter,
   output logic [7:0] watchdogPrescaler,
   output logic halted,
   output logic [7:0] pageView [PAGE_DEPTH]
);
   import bsphio_pkg::*;

   // ****************************************
   // state
   // ****************************************
   // data path, status and watchdog registers with their next values
   logic [7:0] acc_q, acc_d;
   bsphio_flags_type flags_q, flags_d;
   logic [7:0] page_q [PAGE_DEPTH];
   logic [7:0] wdt_q, wdt_d;
   logic [7:0] pre_q, pre_d;
   bsphio_state_type state_q, state_d;

   // ****************************************
   // decode
   // ****************************************
   // an instruction fires only while running; a halted core drops it rather than queueing it
   wire logic running = (state_q == BSPHIO_RUN);
   wire logic fire = instr.valid && running;
   wire logic doSbc = fire && (instr.op == BSPHIO_SBC_IMM);
   wire logic doRd = fire && (instr.op == BSPHIO_PAGE_RD);
   wire logic doWr = fire && (instr.op == BSPHIO_PAGE_WR);
   wire logic doHalt = fire && (instr.op == BSPHIO_HALT);

   // subtract as addition of the complement; bit 8 is the no-borrow carry
   wire logic [8:0] sbcSum = {1'b0, instr.imm} + {1'b0, ~acc_q} + {8'h00, flags_q.carry};
   // low nibble sum on its own; its bit 4 is the half carry
   wire logic [4:0] sbcLow = {1'b0, instr.imm[3:0]} + {1'b0, ~acc_q[3:0]} + {4'h0, flags_q.carry};

   // auxiliary page read port, selected by the 4-bit index
   wire logic [7:0] pageRdData = page_q[instr.idx];

   // accumulator and flag next values
   always_comb begin
      acc_d = acc_q;
      flags_d = flags_q;
      if (doSbc) begin
         acc_d = sbcSum[7:0];
         flags_d.carry = sbcSum[8];
         flags_d.halfCarry = sbcLow[4];
         flags_d.zero = (sbcSum[7:0] == 8'h00);
      end else if (doRd) begin
         acc_d = pageRdData;
      end else if (doHalt) begin
         flags_d.timeoutN = 1'b1;
         flags_d.powerdownN = 1'b0;
      end
   end

   // watchdog prescaler steps on each tick, counter steps as the prescaler wraps; halt clears both
   always_comb begin
      pre_d = pre_q + 8'h01;
      wdt_d = wdt_q;
      if (!wdtTick) begin
         pre_d = pre_q;
      end else if (pre_q == 8'hff) begin
         wdt_d = wdt_q + 8'h01;
      end
      // halt clear wins over a tick that lands in the same cycle
      if (doHalt) begin
         pre_d = `BSPHIO_PRE_CLR;
         wdt_d = `BSPHIO_WDT_CLR;
      end
   end

   // run/halt sequencing; wake-up returns to run
   always_comb begin
      case (state_q)
         BSPHIO_RUN: state_d = doHalt ? BSPHIO_HALTED : BSPHIO_RUN;
         BSPHIO_HALTED: state_d = wakeUp ? BSPHIO_RUN : BSPHIO_HALTED;
         default: state_d = BSPHIO_RUN;
      endcase
   end

   // state registers; the reset branch loads constants only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= `BSPHIO_ACC_RST;
         flags_q <= '{zero: 1'b0, halfCarry: 1'b0, carry: 1'b0,
                      timeoutN: `BSPHIO_TO_RST, powerdownN: `BSPHIO_PD_RST};
         wdt_q <= `BSPHIO_WDT_CLR;
         pre_q <= `BSPHIO_PRE_CLR;
         state_q <= BSPHIO_RUN;
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
         wdt_q <= wdt_d;
         pre_q <= pre_d;
         state_q <= state_d;
      end
   end

   // auxiliary page storage, one flip-flop byte per index
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < PAGE_DEPTH; i++) page_q[i] <= `BSPHIO_PAGE_RST;
      end else if (doWr) begin
         page_q[instr.idx] <= acc_q;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // data straight from flip-flops; ready is the only combinational handshake
   assign instrReady = running; // halted core takes no instruction
   assign accumulator = acc_q;
   assign flags = flags_q;
   assign watchdogCounter = wdt_q;
   assign watchdogPrescaler = pre_q;
   assign halted = (state_q == BSPHIO_HALTED);
   assign pageView = page_q;

   // ****************************************
   // checks
   // ****************************************
   // subtract result, checked as immediate minus accumulator minus the inverted carry
   sbc_result_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc
      |=> accumulator == 8'($past(instr.imm) - $past(acc_q) - {7'h00, !$past(flags_q.carry)}))
      else $error("subtract result wrong");

   // half carry recovered from bit 4 of the result, independent of the nibble adder
   sbc_half_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc
      |=> flags.halfCarry == (accumulator[4] ^ $past(instr.imm[4]) ^ !$past(acc_q[4])))
      else $error("half carry wrong");

   // subtract leaves the two power flags alone
   sbc_power_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc
      |=> $stable({flags.timeoutN, flags.powerdownN}))
      else $error("subtract touched power flags");

   // no borrow when the immediate is larger, whatever the carry in
   sbc_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc && (instr.imm > acc_q)
      |=> flags.carry)
      else $error("carry not set without borrow");

   // a borrow when the immediate is smaller, whatever the carry in
   sbc_borrow_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc && (instr.imm < acc_q)
      |=> !flags.carry)
      else $error("carry set despite borrow");

   // equal operands borrow exactly when the carry in is clear
   sbc_equal_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc && (instr.imm == acc_q)
      |=> flags.carry == $past(flags.carry))
      else $error("carry wrong on equal operands");

   // zero flag follows the 8-bit result
   sbc_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      doSbc
      |=> flags.zero == (accumulator == 8'h00))
      else $error("zero flag mismatch");

   // page read loads the indexed byte and leaves the flags
   page_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      doRd
      |=> accumulator == $past(pageView[instr.idx]) && $stable(flags))
      else $error("page read wrong");

   // page write stores the old accumulator and leaves accumulator and flags
   page_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      doWr
      |=> pageView[$past(instr.idx)] == $past(accumulator) && $stable(accumulator) && $stable(flags))
      else $error("page write wrong");

   // halt clears the watchdog pair and stops the core
   halt_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      doHalt
      |=> watchdogCounter == 8'h00 && watchdogPrescaler == 8'h00 && halted)
      else $error("halt did not clear watchdog");

   // halt sets the timeout flag, clears the power-down flag, keeps the accumulator
   halt_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
      doHalt
      |=> flags.timeoutN && !flags.powerdownN && $stable(accumulator))
      else $error("halt flags wrong");

   // halt leaves the arithmetic flags alone
   halt_others_a: assert property (@(posedge clk) disable iff (!reset_n)
      doHalt
      |=> $stable({flags.zero, flags.halfCarry, flags.carry}))
      else $error("halt touched other flags");

   // a halted core executes nothing until woken
   halt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      halted && !wakeUp
      |=> halted && $stable(accumulator))
      else $error("halted core changed");

   // flags stand while halted, the wake-up cycle included
   halted_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
      halted
      |=> $stable(flags))
      else $error("flags changed while halted");

   // a page write offered while halted is dropped
   halt_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
      halted && instr.valid && (instr.op == BSPHIO_PAGE_WR)
      |=> pageView[$past(instr.idx)] == $past(pageView[instr.idx]))
      else $error("page written while halted");
endmodule // bsphio_core

// file: hw/bsphio_pkg.sv
package bsphio_pkg;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      BSPHIO_NOP,
      BSPHIO_SBC_IMM,
      BSPHIO_PAGE_RD,
      BSPHIO_PAGE_WR,
      BSPHIO_HALT
   } bsphio_op_type;

   typedef struct packed {
      logic valid;
      bsphio_op_type op;
      logic [7:0] imm;
      logic [3:0] idx;
   } bsphio_instr_type;

   typedef struct packed {
      logic zero;
      logic halfCarry;
      logic carry;
      logic timeoutN;
      logic powerdownN;
   } bsphio_flags_type;

   typedef enum logic {
      BSPHIO_RUN,
      BSPHIO_HALTED
   } bsphio_state_type;
endpackage

// file: hw/bsphio_regs.svh
`ifndef BSPHIO_REGS_SVH
`define BSPHIO_REGS_SVH
// ****************************************
// constants
// ****************************************
`define BSPHIO_DATA_W 8
`define BSPHIO_IDX_W 4
`define BSPHIO_PAGE_DEPTH 16
`define BSPHIO_ACC_RST 8'h00
`define BSPHIO_PAGE_RST 8'h00
`define BSPHIO_WDT_CLR 8'h00
`define BSPHIO_PRE_CLR 8'h00
`define BSPHIO_TO_RST 1'b1
`define BSPHIO_PD_RST 1'b1
`define BSPHIO_WDT_W 8
`define BSPHIO_PRE_W 8
`endif

// file: test/bsphio_testbench.sv
`timescale 1ns/1ps
module testbench;
   import bsphio_pkg::*;
   // ********
   // stimulus, outputs and reference
   // ********
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   bsphio_instr_type instr = '0;
   logic wakeUp = 1'b0;
   logic wdtTick = 1'b0;
   logic instrReady, halted, hlt;
   logic [7:0] accumulator, watchdogCounter, watchdogPrescaler, acc, pre, cnt;
   logic [7:0] pageView [16];
   logic [7:0] page [16];
   bsphio_flags_type flags, f;
   logic [42:0] q [$];
   logic [42:0] e;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   bsphio_core DUT (.clk(clk), .reset_n(reset_n), .instr(instr), .wakeUp(wakeUp), .wdtTick(wdtTick),
      .instrReady(instrReady), .accumulator(accumulator), .flags(flags), .watchdogCounter(watchdogCounter),
      .watchdogPrescaler(watchdogPrescaler), .halted(halted), .pageView(pageView));
   // 250 MHz core clock
   initial forever #2 clk = ~clk;
   task check(input logic [38:0] seen, input logic [38:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one cycle: drive on the falling edge, note the result
   task step(input bsphio_op_type op, input logic v, input logic tk, input logic wk);
      logic [8:0] s;
      logic [3:0] ix;
      ix = 4'($urandom);
      @(negedge clk);
      instr = '{v, op, 8'($urandom), ix};
      wdtTick = tk;
      wakeUp = wk;
      {cnt, pre} = {cnt, pre} + 16'(tk); // counter steps as the prescaler wraps
      if (v && !hlt) begin
         case (op)
            BSPHIO_SBC_IMM: begin
               s = {1'b0, instr.imm} + {1'b0, ~acc} + 9'(f.carry);
               f.halfCarry = s[4] ^ instr.imm[4] ^ ~acc[4]; // carry into bit 4
               {f.carry, acc} = s;
               f.zero = (acc == 8'h00);
            end
            BSPHIO_PAGE_RD: acc = page[ix];
            BSPHIO_PAGE_WR: page[ix] = acc;
            BSPHIO_HALT: {cnt, pre, f.timeoutN, f.powerdownN, hlt} = {16'h0000, 3'b101};
            default: ;
         endcase
      end
      hlt = hlt && !wk; // wake-up ends the halt
      q.push_back({ix, acc, f, page[ix], cnt, pre, hlt, !hlt});
   endtask
   // ********
   // monitor and hang guard
   // ********
   always @(posedge clk) begin
      #1;
      cycles++;
      if (cycles > 3000) begin
         failures++;
         report_and_stop();
      end
      if (q.size() > 0) begin
         e = q.pop_front();
         check(39'({accumulator, flags}), 39'(e[38:26]));
         check(39'(pageView[e[42:39]]), 39'(e[25:18]));
         check(39'({watchdogCounter, watchdogPrescaler, halted, instrReady}), 39'(e[17:0]));
      end
   end
   // random traffic, halt, a refused instruction, wake-up
   initial begin
      page = '{default: 8'h00};
      {acc, pre, cnt, f, hlt} = {24'h000000, 5'h03, 1'b0}; // active-low flags idle high
      void'($urandom(60));
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      for (int k = 0; k < 2; k++) begin
         repeat (300) step(bsphio_op_type'($urandom_range(0, 3)), 1'($urandom), 1'($urandom), 1'b0);
         step(BSPHIO_HALT, 1'b1, 1'b1, 1'b0);
         step(bsphio_op_type'($urandom_range(1, 4)), 1'b1, 1'b0, 1'b0);
         step(BSPHIO_NOP, 1'b0, 1'b0, 1'b1);
      end
      repeat (2) @(negedge clk);
      report_and_stop();
   end
endmodule // testbench
